// ===== axil_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_map.svh"

module axil_port
  import eeprom_pkg::*;
(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  // write address / data / response
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [`ADDR_W-1:0]  awaddr,
  input  wire logic                wvalid,
  output logic                     wready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  output logic                     bvalid,
  input  wire logic                bready,
  output logic      [1:0]          bresp,
  // read address / data
  input  wire logic                arvalid,
  output logic                     arready,
  input  wire logic [`ADDR_W-1:0]  araddr,
  output logic                     rvalid,
  input  wire logic                rready,
  output logic      [31:0]         rdata,
  output logic      [1:0]          rresp,
  // local side
  output logic                     wr_en,
  output bus_req_s                 wr_req,
  input  wire logic                wr_hit,
  output logic                     rd_en,
  output logic      [9:0]          rd_idx,
  input  wire logic [7:0]          rd_data,
  input  wire logic                rd_hit
);
  wr_state_e wr_state_q;
  rd_state_e rd_state_q;
  logic      aw_have_q;
  logic      w_have_q;
  logic      lane_q;
  logic      fire;

  // address and data are taken in either order
  assign awready = !aw_have_q && wr_state_q == WR_IDLE;
  assign wready  = !w_have_q && wr_state_q == WR_IDLE;
  assign fire    = aw_have_q && w_have_q && wr_state_q == WR_IDLE;
  assign wr_en   = fire && lane_q; // only byte lane 0 carries data
  assign bvalid  = wr_state_q == WR_RESP;

  // write channel holding registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      lane_q     <= 1'b0;
      wr_req     <= '0;
      wr_state_q <= WR_IDLE;
      bresp      <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_have_q  <= 1'b1;
        wr_req.idx <= awaddr[`ADDR_W-1:2];
      end
      if (wvalid && wready) begin
        w_have_q    <= 1'b1;
        wr_req.data <= wdata[7:0];
        lane_q      <= wstrb[0];
      end
      case (wr_state_q)
        WR_IDLE: begin
          if (fire) begin
            aw_have_q  <= 1'b0;
            w_have_q   <= 1'b0;
            bresp      <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            wr_state_q <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (bready) begin
            wr_state_q <= WR_IDLE;
          end
        end
        default: wr_state_q <= WR_IDLE;
      endcase
    end
  end

  assign arready = rd_state_q == RD_IDLE;
  assign rvalid  = rd_state_q == RD_RESP;
  assign rd_en   = rd_state_q == RD_FETCH;

  // read channel: address, one fetch cycle, response
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_state_q <= RD_IDLE;
      rd_idx     <= '0;
      rdata      <= '0;
      rresp      <= `RESP_OKAY;
    end else begin
      case (rd_state_q)
        RD_IDLE: begin
          if (arvalid) begin
            rd_idx     <= araddr[`ADDR_W-1:2];
            rd_state_q <= RD_FETCH;
          end
        end
        RD_FETCH: begin
          rdata      <= {24'h0, rd_data};
          rresp      <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
          rd_state_q <= RD_RESP;
        end
        RD_RESP: begin
          if (rready) begin
            rd_state_q <= RD_IDLE;
          end
        end
        default: rd_state_q <= RD_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== eeprom_cells.sv
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_map.svh"

module eeprom_cells
  import eeprom_pkg::*;
#(
  parameter int ARRAY_BYTES = `ARRAY_BYTES,
  parameter int BLOCK_BYTES = `BLOCK_BYTES
) (
  // clock
  input  wire logic       ref_clk,
  // operation
  input  wire logic       commit,
  input  wire logic [1:0] mode,
  input  wire bus_req_s   op,
  // read side
  input  wire logic [9:0] rd_idx,
  output logic      [7:0] rd_byte,
  output logic      [7:0] cfg_byte
);
  localparam int AW = $clog2(ARRAY_BYTES);
  localparam int BW = $clog2(ARRAY_BYTES / BLOCK_BYTES);

  // factory state: erased array, unprotected configuration
  logic [7:0] mem_q [ARRAY_BYTES] = '{default: `CELL_ERASED};
  logic [7:0] cfg_q               = `CFG_FACTORY;

  // nonvolatile cells: untouched by reset
  always_ff @(posedge ref_clk) begin
    if (commit) begin
      for (int i = 0; i < ARRAY_BYTES; i++) begin
        case (mode)
          `MODE_PROGRAM: begin
            if (op.idx == 10'(i)) begin
              mem_q[i] <= mem_q[i] & op.data;
            end
          end
          `MODE_BYTE_ERASE: begin
            if (op.idx == 10'(i)) begin
              mem_q[i] <= `CELL_ERASED;
            end
          end
          `MODE_BLOCK_ERASE: begin
            if (op.idx[AW-1 -: BW] == BW'(i / BLOCK_BYTES)) begin
              mem_q[i] <= `CELL_ERASED;
            end
          end
          default: begin
            mem_q[i] <= `CELL_ERASED;
          end
        endcase
      end
    end
  end

  // configuration byte: program or byte erase only
  always_ff @(posedge ref_clk) begin
    if (commit && op.idx == `IDX_CFG) begin
      if (mode == `MODE_PROGRAM) begin
        cfg_q <= cfg_q & op.data;
      end else if (mode == `MODE_BYTE_ERASE) begin
        cfg_q <= `CELL_ERASED;
      end
    end
  end

  assign rd_byte  = mem_q[rd_idx[AW-1:0]];
  assign cfg_byte = cfg_q;

endmodule
`default_nettype wire

// ===== eeprom_map.svh
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

// ----------------------------------------------------------------------------
// address map: word index = byte address bits [11:2]
// ----------------------------------------------------------------------------
`define ADDR_W          12
`define IDX_W           10
`define ARRAY_BYTES     512
`define BLOCK_BYTES     128
`define IDX_CFG         10'h200
`define IDX_CTRL        10'h201
`define IDX_SHADOW      10'h202
`define IDX_STATUS      10'h203

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define CTRL_HV_BIT     0
`define CTRL_LATCH_BIT  1
`define CTRL_ERLO_BIT   2
`define CTRL_ERHI_BIT   3
`define CTRL_RST        4'h0

// ----------------------------------------------------------------------------
// operation codes of the two erase mode bits {hi, lo}
// ----------------------------------------------------------------------------
`define MODE_PROGRAM    2'h0
`define MODE_BYTE_ERASE 2'h1
`define MODE_BLOCK_ERASE 2'h2
`define MODE_BULK_ERASE 2'h3

// ----------------------------------------------------------------------------
// cell and configuration values
// ----------------------------------------------------------------------------
`define CELL_ERASED     8'hff
`define CFG_FACTORY     8'h10
`define SHADOW_RST      8'h0f
`define PROT_LSB        0

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS   10
`define HV_TIME_NS      10000

// ----------------------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------------------
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ===== eeprom_pe_ctrl.sv
// Behaviour
// - internal pump programs/erases 512-byte array
// - shadow reloads from config after reset, read
// - factory: array all ones, config bit4 one
// - program only clears bits; erase sets
// - voltage only on unprotected array or config
// - nonzero erase mode bits select erase
// - latch captures only valid array or config writes
// - later valid write replaces captured byte
// - array reads return latched data while latched
// - latched control writes accepted after capture
// - enable refused: latch clear, non-array write
// - enable starts pump; clear stops it
// - clearing enable and latch clears enable only
// - mode codes: program, byte, block, bulk
// - four 128-byte blocks, protected ones untouched
// - latch cannot clear while enable set
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_map.svh"

module eeprom_pe_ctrl
  import eeprom_pkg::*;
#(
  parameter int ARRAY_BYTES = `ARRAY_BYTES,
  parameter int BLOCK_BYTES = `BLOCK_BYTES,
  parameter int HV_TIME_NS  = `HV_TIME_NS
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  // axi4-lite write
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [`ADDR_W-1:0] awaddr,
  input  wire logic               wvalid,
  output logic                    wready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  output logic                    bvalid,
  input  wire logic               bready,
  output logic      [1:0]         bresp,
  // axi4-lite read
  input  wire logic               arvalid,
  output logic                    arready,
  input  wire logic [`ADDR_W-1:0] araddr,
  output logic                    rvalid,
  input  wire logic               rready,
  output logic      [31:0]        rdata,
  output logic      [1:0]         rresp,
  // charge pump
  output logic                    pump_en
);
  // --------------------------------------------------------------------------
  // constants
  // --------------------------------------------------------------------------
  localparam int HV_RAW    = (HV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int HV_CYCLES = (HV_RAW < 1) ? 1 : HV_RAW;
  localparam int CW        = $clog2(HV_CYCLES + 1);
  localparam logic [CW-1:0] HV_LAST = CW'(HV_CYCLES - 1);
  localparam int AW        = $clog2(ARRAY_BYTES);
  localparam int BW        = $clog2(ARRAY_BYTES / BLOCK_BYTES);

  // --------------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------------
  logic          wr_en;
  bus_req_s      wr_req;
  logic          wr_hit;
  logic          rd_en;
  logic [9:0]    rd_idx;
  logic [7:0]    rd_data;
  logic          rd_hit;
  logic [7:0]    cell_byte;
  logic [7:0]    cfg_byte;
  ctrl_s         ctrl_q;
  bus_req_s      lat_q;
  logic          captured_q;
  logic          nonarray_q;
  logic [7:0]    shadow_q;
  logic          load_q;
  logic [CW-1:0] hv_cnt_q;
  logic          done_q;
  logic          commit;
  logic [1:0]    mode;
  logic          wr_loc;
  logic          wr_ctrl;
  logic          wr_other;
  logic          rd_arr;
  logic          lat_cfg;
  logic [3:0]    prot;
  logic          prot_hit;
  logic          hv_apply_d;
  logic [7:0]    wd;

  // --------------------------------------------------------------------------
  // bus slave and cell array
  // --------------------------------------------------------------------------
  axil_port u_bus (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .wr_en   (wr_en),
    .wr_req  (wr_req),
    .wr_hit  (wr_hit),
    .rd_en   (rd_en),
    .rd_idx  (rd_idx),
    .rd_data (rd_data),
    .rd_hit  (rd_hit)
  );

  eeprom_cells #(
    .ARRAY_BYTES (ARRAY_BYTES),
    .BLOCK_BYTES (BLOCK_BYTES)
  ) u_cells (
    .ref_clk  (ref_clk),
    .commit   (commit),
    .mode     (mode),
    .op       (lat_q),
    .rd_idx   (rd_idx),
    .rd_byte  (cell_byte),
    .cfg_byte (cfg_byte)
  );

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  assign wd       = wr_req.data;
  assign wr_hit   = wr_req.idx <= `IDX_STATUS;
  assign rd_hit   = rd_idx <= `IDX_STATUS;
  assign wr_loc   = wr_en && (wr_req.idx < 10'(ARRAY_BYTES) || wr_req.idx == `IDX_CFG);
  assign wr_ctrl  = wr_en && wr_req.idx == `IDX_CTRL;
  assign wr_other = wr_en && !wr_loc && !wr_ctrl;
  assign rd_arr   = rd_idx < 10'(ARRAY_BYTES);

  // --------------------------------------------------------------------------
  // control register
  // --------------------------------------------------------------------------
  // latch held while enable set; mode frozen while enable set
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `CTRL_RST;
    end else if (wr_ctrl) begin
      if (ctrl_q.bus_latch_bit && !captured_q) begin
        ctrl_q.bus_latch_bit <= wd[`CTRL_LATCH_BIT] || ctrl_q.high_voltage_enable;
      end else begin
        if (!ctrl_q.high_voltage_enable) begin
          ctrl_q.erase_mode_hi <= wd[`CTRL_ERHI_BIT];
          ctrl_q.erase_mode_lo <= wd[`CTRL_ERLO_BIT];
        end
        ctrl_q.high_voltage_enable <= wd[`CTRL_HV_BIT] &&
          (ctrl_q.high_voltage_enable || ctrl_q.bus_latch_bit || !nonarray_q);
        ctrl_q.bus_latch_bit <= wd[`CTRL_LATCH_BIT] || ctrl_q.high_voltage_enable;
      end
    end
  end

  // --------------------------------------------------------------------------
  // address and data latch
  // --------------------------------------------------------------------------
  // last valid location written under latch is kept
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lat_q      <= '0;
      captured_q <= 1'b0;
    end else if (wr_loc && ctrl_q.bus_latch_bit) begin
      lat_q      <= wr_req;
      captured_q <= 1'b1;
    end else if (!ctrl_q.bus_latch_bit) begin
      captured_q <= 1'b0;
    end
  end

  // non-array write seen since last array or config write
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      nonarray_q <= 1'b0;
    end else if (wr_other) begin
      nonarray_q <= 1'b1;
    end else if (wr_loc) begin
      nonarray_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // protection shadow
  // --------------------------------------------------------------------------
  // all blocks protected until the first load after reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      load_q   <= 1'b1;
      shadow_q <= `SHADOW_RST;
    end else begin
      load_q <= 1'b0;
      if (load_q || (rd_en && rd_idx == `IDX_CFG)) begin
        shadow_q <= cfg_byte;
      end
    end
  end

  // --------------------------------------------------------------------------
  // high voltage interlock
  // --------------------------------------------------------------------------
  assign mode    = {ctrl_q.erase_mode_hi, ctrl_q.erase_mode_lo};
  assign lat_cfg = lat_q.idx == `IDX_CFG;
  assign prot    = shadow_q[`PROT_LSB +: 4];

  // a refused target never gets voltage
  always_comb begin
    if (lat_cfg) begin
      prot_hit = mode == `MODE_BLOCK_ERASE || mode == `MODE_BULK_ERASE;
    end else if (mode == `MODE_BULK_ERASE) begin
      prot_hit = |prot;
    end else begin
      prot_hit = prot[lat_q.idx[AW-1 -: BW]];
    end
  end

  assign hv_apply_d = ctrl_q.high_voltage_enable && ctrl_q.bus_latch_bit &&
                      captured_q && !prot_hit;

  // pump drive and exposure timer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pump_en  <= 1'b0;
      hv_cnt_q <= '0;
      done_q   <= 1'b0;
    end else begin
      pump_en <= hv_apply_d;
      if (!pump_en) begin
        hv_cnt_q <= '0;
        done_q   <= 1'b0;
      end else if (!done_q) begin
        if (hv_cnt_q == HV_LAST) begin
          done_q <= 1'b1;
        end else begin
          hv_cnt_q <= hv_cnt_q + 1'b1;
        end
      end
    end
  end

  // cells change once after a full exposure
  assign commit = pump_en && !done_q && hv_cnt_q == HV_LAST;

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  always_comb begin
    if (rd_arr) begin
      rd_data = ctrl_q.bus_latch_bit ? lat_q.data : cell_byte;
    end else begin
      case (rd_idx)
        `IDX_CFG:    rd_data = cfg_byte;
        `IDX_CTRL:   rd_data = {4'h0, ctrl_q};
        `IDX_SHADOW: rd_data = shadow_q;
        `IDX_STATUS: rd_data = {4'h0, done_q, nonarray_q, captured_q, pump_en};
        default:     rd_data = 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_latched_write;
    ctrl_q.bus_latch_bit ##0 wr_loc;
  endsequence

  sequence s_enable_held;
    ctrl_q.high_voltage_enable ##0 ctrl_q.bus_latch_bit;
  endsequence

  property p_capture;
    s_latched_write |=> captured_q && lat_q == $past(wr_req);
  endproperty
  a_capture: assert property (p_capture) else $error("valid latched write not captured");

  property p_no_capture;
    wr_en && !wr_loc |=> $stable(lat_q);
  endproperty
  a_no_capture: assert property (p_no_capture) else $error("invalid write changed latch");

  property p_latch_hold;
    s_enable_held |=> ctrl_q.bus_latch_bit;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch cleared under enable");

  property p_mode_frozen;
    ctrl_q.high_voltage_enable |=> $stable(mode);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed under enable");

  property p_refuse_enable;
    wr_ctrl && !ctrl_q.bus_latch_bit && nonarray_q && !ctrl_q.high_voltage_enable
      |=> !ctrl_q.high_voltage_enable;
  endproperty
  a_refuse_enable: assert property (p_refuse_enable) else $error("enable set out of order");

  property p_pump_follow;
    s_enable_held ##0 captured_q ##0 !prot_hit |=> pump_en ##1 (pump_en || !$past(hv_apply_d));
  endproperty
  a_pump_follow: assert property (p_pump_follow) else $error("pump did not start");

  property p_pump_stop;
    !ctrl_q.high_voltage_enable |=> !pump_en;
  endproperty
  a_pump_stop: assert property (p_pump_stop) else $error("pump left running");

  property p_protected;
    pump_en |-> !$past(prot_hit);
  endproperty
  a_protected: assert property (p_protected) else $error("voltage on protected target");

  property p_read_latched;
    rd_en && rd_arr && ctrl_q.bus_latch_bit |-> rd_data == lat_q.data;
  endproperty
  a_read_latched: assert property (p_read_latched) else $error("array read bypassed latch");

  property p_shadow_load;
    rd_en && rd_idx == `IDX_CFG |=> shadow_q == $past(cfg_byte);
  endproperty
  a_shadow_load: assert property (p_shadow_load) else $error("shadow not reloaded");

endmodule
`default_nettype wire

// ===== eeprom_pkg.sv
`default_nettype none
package eeprom_pkg;

  // one local bus write: word index and low data byte
  typedef struct packed {
    logic [9:0] idx;
    logic [7:0] data;
  } bus_req_s;

  // control register image
  typedef struct packed {
    logic erase_mode_hi;
    logic erase_mode_lo;
    logic bus_latch_bit;
    logic high_voltage_enable;
  } ctrl_s;

  typedef enum logic [0:0] {WR_IDLE, WR_RESP} wr_state_e;
  typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_RESP} rd_state_e;

endpackage
`default_nettype wire

// ===== test_eeprom_pe_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module test_eeprom_pe_ctrl
  import eeprom_pkg::*;
;
  // ---------------------------------------------------------------
  // clock, bus signals and counters
  // ---------------------------------------------------------------
  logic        ref_clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, pump_en;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_seen;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp_seen;
  int          err_total, cmp_count;

  eeprom_pe_ctrl #(.HV_TIME_NS(100)) DUT (
    .ref_clk(ref_clk), .resetn(resetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .pump_en(pump_en));

  // 100 mhz clock
  always #5 ref_clk = ~ref_clk;

  // ---------------------------------------------------------------
  // compare, verdict and bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // write one byte; address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    wstrb   <= 4'h1;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    if (n >= 100) err_total++;
    resp_seen = bresp;
    bready <= 1'b0;
  endtask

  // read one word and compare it
  task automatic rc(input logic [11:0] a, input logic [31:0] exp, input string nm);
    int n;
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    if (n >= 100) err_total++;
    rd_seen = rdata;
    resp_seen = rresp;
    rready <= 1'b0;
    chk(nm, rd_seen, exp);
  endtask

  // full latch / capture / high voltage sequence in one mode
  task automatic op(input logic [1:0] m, input logic [11:0] a, input logic [7:0] d,
                    input logic pe);
    wr(12'h804, {4'h0, m, 2'h2});
    wr(a, d);
    wr(12'h804, {4'h0, m, 2'h3});
    // pump register updates on the edge that ends the write
    @(posedge ref_clk);
    chk("pump_en", {31'h0, pump_en}, {31'h0, pe});
    repeat (12) @(posedge ref_clk);
    wr(12'h804, {4'h0, m, 2'h2});
    wr(12'h804, 8'h00);
  endtask

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  initial begin
    #400000;
    err_total++;
    summarize();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 0; resetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
    rready = 0; awaddr = 0; araddr = 0; wdata = 0; wstrb = 0;
    err_total = 0; cmp_count = 0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    rc(12'h804, 32'h0, "ctrl_reset");
    rc(12'h808, 32'h10, "shadow_loaded");
    rc(12'h000, 32'hff, "array_erased");
    chk("pump_idle", {31'h0, pump_en}, 32'h0);
    // enable refused after a non-array write with the latch clear
    wr(12'h808, 8'h00);
    wr(12'h804, 8'h01);
    rc(12'h804, 32'h0, "hv_refused");
    wr(12'h804, 8'h02);
    wr(12'h804, 8'h03);
    rc(12'h804, 32'h2, "hv_before_capture");
    wr(12'hffc, 8'h00);
    chk("unmapped_resp", {30'h0, resp_seen}, 32'h2);
    rc(12'hffc, 32'h0, "unmapped_rd");
    chk("unmapped_rresp", {30'h0, resp_seen}, 32'h2);
    wr(12'h004, 8'ha5);
    chk("array_wr_resp", {30'h0, resp_seen}, 32'h0);
    wr(12'h008, 8'h3c);
    rc(12'h00c, 32'h3c, "latched_read");
    wr(12'h804, 8'h03);
    @(posedge ref_clk);
    chk("pump_on", {31'h0, pump_en}, 32'h1);
    wr(12'h804, 8'h01);
    rc(12'h804, 32'h3, "latch_held");
    repeat (12) @(posedge ref_clk);
    wr(12'h804, 8'h00);
    rc(12'h804, 32'h2, "clear_both");
    chk("pump_off", {31'h0, pump_en}, 32'h0);
    wr(12'h804, 8'h00);
    rc(12'h804, 32'h0, "latch_cleared");
    rc(12'h008, 32'h3c, "programmed");
    rc(12'h004, 32'hff, "replaced_untouched");
    // program only clears bits, erase sets them
    op(2'h0, 12'h008, 8'hf0, 1'b1);
    rc(12'h008, 32'h30, "and_program");
    op(2'h1, 12'h008, 8'h00, 1'b1);
    rc(12'h008, 32'hff, "byte_erase");
    // protect everything via the configuration byte
    op(2'h1, 12'h800, 8'h00, 1'b1);
    rc(12'h800, 32'hff, "cfg_erased");
    rc(12'h808, 32'hff, "shadow_reload");
    op(2'h0, 12'h00c, 8'h00, 1'b0);
    rc(12'h00c, 32'hff, "protected_kept");
    op(2'h3, 12'h000, 8'h00, 1'b0);
    // unprotect again, then block and bulk erase
    op(2'h0, 12'h800, 8'hf0, 1'b1);
    rc(12'h800, 32'hf0, "cfg_programmed");
    rc(12'h808, 32'hf0, "shadow_unprot");
    op(2'h0, 12'h200, 8'h00, 1'b1);
    op(2'h0, 12'h00c, 8'h0f, 1'b1);
    op(2'h2, 12'h204, 8'h11, 1'b1);
    rc(12'h200, 32'hff, "block_erased");
    rc(12'h00c, 32'h0f, "other_block_kept");
    op(2'h3, 12'h000, 8'h00, 1'b1);
    rc(12'h00c, 32'hff, "bulk_erased");
    rc(12'h800, 32'hf0, "cfg_not_bulked");
    summarize();
  end
endmodule

`default_nettype wire
